// file: inc/t8w_pkg.sv
// Constants, register map and mode classes for the 8-bit waveform timer.
package t8w_pkg;

    // ****************************************************************
    // Counter limits
    // ****************************************************************
    localparam int         CNT_W      = 8;
    localparam logic [7:0] CNT_MAX    = 8'hFF;
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam logic [7:0] CNT_ONE    = 8'h01;
    localparam logic [7:0] RST_BYTE   = 8'h00;

    // ****************************************************************
    // Waveform mode codes and output action codes
    // ****************************************************************
    localparam logic [2:0] MODE_NORMAL    = 3'h0;
    localparam logic [2:0] MODE_PHASE_MAX = 3'h1;
    localparam logic [2:0] MODE_CTC       = 3'h2;
    localparam logic [2:0] MODE_FAST_MAX  = 3'h3;
    localparam logic [2:0] MODE_PHASE_CMP = 3'h5;
    localparam logic [2:0] MODE_FAST_CMP  = 3'h7;
    localparam int         MODE_HIGH_BIT  = 2;

    localparam logic [1:0] ACT_OFF    = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR  = 2'h2;
    localparam logic [1:0] ACT_SET    = 2'h3;
    localparam int         ACT_PWM_BIT = 1;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam int         MIN_ADDR_W = 5;
    localparam logic [4:0] ADDR_CTRL  = 5'h00;
    localparam logic [4:0] ADDR_COUNT = 5'h04;
    localparam logic [4:0] ADDR_CMPA  = 5'h08;
    localparam logic [4:0] ADDR_CMPB  = 5'h0C;
    localparam logic [4:0] ADDR_FLAGS = 5'h10;

    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_ACTB_LSB = 4;
    localparam int CTRL_ACTA_LSB = 6;

    localparam int FLAG_OVF  = 0;
    localparam int FLAG_CMPA = 1;
    localparam int FLAG_CMPB = 2;

    typedef enum logic [1:0] {CLS_NORMAL, CLS_CTC, CLS_FAST, CLS_PHASE} t8w_class_e;

endpackage

// file: inc/t8w_cmp_if.sv
// Interface carrying counter events from the timer core to one compare output unit.
`timescale 1ns/1ps
interface t8w_cmp_if;
    logic match;
    logic restart;
    logic dir_up;
    logic pwm;
    logic fast;
    logic cmp_is_top;
    logic toggle_ok;

    modport timer (output match, output restart, output dir_up, output pwm, output fast,
                   output cmp_is_top, output toggle_ok);
    modport unit  (input match, input restart, input dir_up, input pwm, input fast,
                   input cmp_is_top, input toggle_ok);
endinterface

// file: core/t8w_compare.sv
// Compare output unit: drives one waveform output from counter match events.
`timescale 1ns/1ps
module t8w_compare
    import t8w_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rstn,
    t8w_cmp_if.unit         ev,
    input  wire logic [1:0] action_sel,
    output logic            wave,
    output logic            connected
);

    logic [1:0] act_reg;
    logic       hit;
    logic       toggle_allowed;

    // ****************************************************************
    // Match qualification
    // ****************************************************************
    // In PWM modes a compare value equal to TOP with a PWM action ignores the match.
    assign hit            = ev.match && !(ev.pwm && ev.cmp_is_top && action_sel[ACT_PWM_BIT]);
    assign toggle_allowed = !ev.pwm || ev.toggle_ok;

    // New action bits only become active at the first match after the write.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            act_reg <= ACT_OFF;
        end else if (hit) begin
            act_reg <= action_sel;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            connected <= 1'b0;
        end else begin
            connected <= (act_reg != ACT_OFF) && (act_reg != ACT_TOGGLE || toggle_allowed);
        end
    end

    // ****************************************************************
    // Output state
    // ****************************************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wave <= 1'b0;
        end else if (hit) begin
            unique case (action_sel)
                ACT_TOGGLE: wave <= toggle_allowed ? !wave : wave;
                ACT_CLEAR:  wave <= ev.pwm && !ev.fast && !ev.dir_up;
                ACT_SET:    wave <= !(ev.pwm && !ev.fast && !ev.dir_up);
                default:    wave <= wave;
            endcase
        end else if (ev.restart && act_reg[ACT_PWM_BIT]) begin
            wave <= (act_reg == ACT_CLEAR);
        end
    end

    property p_off_disconnects;
        @(posedge clk) disable iff (!rstn)
        (act_reg == ACT_OFF) |=> !connected;
    endproperty
    a_off_disconnects: assert property (p_off_disconnects) else $error("output connected with action off");

endmodule

// file: core/t8w_timer.sv
// Top of the 8-bit timer: counter sequencing, compare buffers, flags and registers.
//
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/1ps
// Behaviour
// - Mode 0 counts up only, wrapping from 0xFF to zero.
// - Normal mode sets overflow flag as counter becomes zero; counting never clears it.
// - Overflow flag clears when its interrupt is serviced.
// - Counter writes are accepted any time and take effect at once.
// - Mode 2 clears the counter when it matches compare A, which is TOP.
// - Compare A is unbuffered in CLEAR_ON_MATCH_MODE; writing below count delays match past wrap.
// - Compare A flag sets each time the counter reaches TOP in CLEAR_ON_MATCH_MODE.
// - CLEAR_ON_MATCH_MODE with output A mode 1 toggles output A on each match.
// - CLEAR_ON_MATCH_MODE sets overflow flag as the counter passes from 0xFF to zero.
// - Modes 3 and 7 count zero to TOP; TOP is 0xFF or compare A.
// - Fast PWM mode 2 clears on match, sets at zero; mode 3 reversed.
// - Fast PWM counts up to TOP, then clears on the next timer cycle.
// - Fast PWM sets overflow flag each time counter passes from TOP to zero.
// - Output A mode 1 toggles in PWM with high mode bit; not output B.
// - Fast PWM compare zero gives spikes; compare max gives constant output.
// - Fast PWM compare registers are double buffered; period 256 timer cycles in mode 3, compare A plus one in mode 7.
// - Modes 1 and 5 count up to TOP and back down; TOP 0xFF or A.
// - Phase PWM clears on up-match, sets on down-match; inverting reverses both.
// - Phase PWM holds TOP for one timer cycle, then reverses direction.
// - Phase PWM sets overflow flag each time the counter leaves zero and turns back up.
// - Output action 0 leaves the pin to the port, output disconnected.
// - Output action changes take effect at the first match after the write.
module t8w_timer
    import t8w_pkg::*;
#(
    parameter int ADDR_W = 5
) (
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic              timer_tick,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [7:0]        wdata,
    input  wire logic              wr_stb,
    input  wire logic              rd_stb,
    output logic      [7:0]        rdata,
    input  wire logic              ovf_ack,
    input  wire logic              cmpa_ack,
    input  wire logic              cmpb_ack,
    output logic                   overflow_flag,
    output logic                   compare_a_flag,
    output logic                   compare_b_flag,
    output logic                   wave_out_a,
    output logic                   wave_out_b,
    output logic                   wave_a_connected,
    output logic                   wave_b_connected
);

    // ****************************************************************
    // Parameter check
    // ****************************************************************
    if (ADDR_W < MIN_ADDR_W) begin : g_bad_addr_w
        $error("ADDR_W too small for the register map");
    end

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [7:0]  ctrl_reg;
    logic [7:0]  count_value_reg;
    logic [7:0]  count_value_next;
    logic        dir_up_reg;
    logic        dir_up_next;
    logic [7:0]  compare_a_value_reg;
    logic [7:0]  compare_b_value_reg;
    logic [7:0]  cmpa_act_reg;
    logic [7:0]  cmpb_act_reg;
    logic [7:0]  cmpa_eff;
    logic [7:0]  cmpb_eff;
    logic [7:0]  top_value;
    logic [2:0]  waveform_mode_sel;
    logic [1:0]  out_a_action_sel;
    logic [1:0]  out_b_action_sel;
    t8w_class_e  mode_class;
    logic        is_pwm;
    logic        at_top;
    logic        at_top_zero;
    logic        cnt_wr;
    logic        flag_wr;
    logic        ovf_set;
    logic        cmpa_set;
    logic        cmpb_set;
    logic [ADDR_W-1:0] a_ctrl;
    logic [ADDR_W-1:0] a_count;
    logic [ADDR_W-1:0] a_cmpa;
    logic [ADDR_W-1:0] a_cmpb;
    logic [ADDR_W-1:0] a_flags;

    t8w_cmp_if if_a ();
    t8w_cmp_if if_b ();

    assign a_ctrl  = ADDR_W'(ADDR_CTRL);
    assign a_count = ADDR_W'(ADDR_COUNT);
    assign a_cmpa  = ADDR_W'(ADDR_CMPA);
    assign a_cmpb  = ADDR_W'(ADDR_CMPB);
    assign a_flags = ADDR_W'(ADDR_FLAGS);

    assign waveform_mode_sel = ctrl_reg[CTRL_MODE_LSB +: 3];
    assign out_a_action_sel  = ctrl_reg[CTRL_ACTA_LSB +: 2];
    assign out_b_action_sel  = ctrl_reg[CTRL_ACTB_LSB +: 2];

    assign cnt_wr  = wr_stb && (addr == a_count);
    assign flag_wr = wr_stb && (addr == a_flags);

    // ****************************************************************
    // Mode decode and TOP selection
    // ****************************************************************
    // Reserved codes 4 and 6 run as a plain up-counter so the block never locks up.
    always_comb begin
        unique case (waveform_mode_sel)
            MODE_CTC:                       mode_class = CLS_CTC;
            MODE_FAST_MAX, MODE_FAST_CMP:   mode_class = CLS_FAST;
            MODE_PHASE_MAX, MODE_PHASE_CMP: mode_class = CLS_PHASE;
            default:                        mode_class = CLS_NORMAL;
        endcase
    end

    assign is_pwm = (mode_class == CLS_FAST) || (mode_class == CLS_PHASE);

    // PWM modes match against the active copies; other modes see writes at once.
    assign cmpa_eff = is_pwm ? cmpa_act_reg : compare_a_value_reg;
    assign cmpb_eff = is_pwm ? cmpb_act_reg : compare_b_value_reg;

    always_comb begin
        unique case (mode_class)
            CLS_CTC:             top_value = compare_a_value_reg;
            CLS_FAST, CLS_PHASE: top_value = waveform_mode_sel[MODE_HIGH_BIT] ? cmpa_act_reg : CNT_MAX;
            default:             top_value = CNT_MAX;
        endcase
    end

    assign at_top      = (count_value_reg == top_value);
    assign at_top_zero = (top_value == CNT_BOTTOM);

    // ****************************************************************
    // Counter sequencing
    // ****************************************************************
    always_comb begin
        count_value_next = count_value_reg;
        dir_up_next      = dir_up_reg;
        unique case (mode_class)
            CLS_CTC: begin
                // A lowered TOP below the count is missed until the counter wraps.
                count_value_next = (count_value_reg == compare_a_value_reg) ? CNT_BOTTOM
                                                                            : count_value_reg + CNT_ONE;
                dir_up_next = 1'b1;
            end
            CLS_FAST: begin
                count_value_next = at_top ? CNT_BOTTOM : count_value_reg + CNT_ONE;
                dir_up_next = 1'b1;
            end
            CLS_PHASE: begin
                if (dir_up_reg) begin
                    if (count_value_reg >= top_value) begin
                        count_value_next = (count_value_reg == CNT_BOTTOM) ? CNT_BOTTOM
                                                                           : count_value_reg - CNT_ONE;
                        dir_up_next = 1'b0;
                    end else begin
                        count_value_next = count_value_reg + CNT_ONE;
                    end
                end else if (count_value_reg == CNT_BOTTOM) begin
                    count_value_next = CNT_ONE;
                    dir_up_next      = 1'b1;
                end else begin
                    count_value_next = count_value_reg - CNT_ONE;
                end
            end
            default: begin
                count_value_next = count_value_reg + CNT_ONE;
                dir_up_next      = 1'b1;
            end
        endcase
    end

    // A software write beats a coincident timer tick.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count_value_reg <= RST_BYTE;
            dir_up_reg      <= 1'b1;
        end else if (cnt_wr) begin
            count_value_reg <= wdata;
        end else if (timer_tick) begin
            count_value_reg <= count_value_next;
            dir_up_reg      <= dir_up_next;
        end
    end

    // ****************************************************************
    // Register writes and compare buffers
    // ****************************************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_reg            <= RST_BYTE;
            compare_a_value_reg <= RST_BYTE;
            compare_b_value_reg <= RST_BYTE;
        end else if (wr_stb) begin
            if (addr == a_ctrl) begin
                ctrl_reg <= wdata;
            end
            if (addr == a_cmpa) begin
                compare_a_value_reg <= wdata;
            end
            if (addr == a_cmpb) begin
                compare_b_value_reg <= wdata;
            end
        end
    end

    // The active copies reload at TOP so a PWM period never sees a half-updated duty.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cmpa_act_reg <= RST_BYTE;
            cmpb_act_reg <= RST_BYTE;
        end else if (!is_pwm || (timer_tick && at_top)) begin
            cmpa_act_reg <= compare_a_value_reg;
            cmpb_act_reg <= compare_b_value_reg;
        end
    end

    // ****************************************************************
    // Flags
    // ****************************************************************
    always_comb begin
        unique case (mode_class)
            CLS_FAST:  ovf_set = timer_tick && at_top;
            CLS_PHASE: ovf_set = timer_tick && !dir_up_reg && (count_value_reg == CNT_BOTTOM);
            default:   ovf_set = timer_tick && (count_value_reg == CNT_MAX);
        endcase
    end

    assign cmpa_set = timer_tick && (count_value_reg == cmpa_eff);
    assign cmpb_set = timer_tick && (count_value_reg == cmpb_eff);

    // Hardware set wins over acknowledge or write-one-to-clear in the same cycle.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            overflow_flag  <= 1'b0;
            compare_a_flag <= 1'b0;
            compare_b_flag <= 1'b0;
        end else begin
            if (ovf_set) begin
                overflow_flag <= 1'b1;
            end else if (ovf_ack || (flag_wr && wdata[FLAG_OVF])) begin
                overflow_flag <= 1'b0;
            end
            if (cmpa_set) begin
                compare_a_flag <= 1'b1;
            end else if (cmpa_ack || (flag_wr && wdata[FLAG_CMPA])) begin
                compare_a_flag <= 1'b0;
            end
            if (cmpb_set) begin
                compare_b_flag <= 1'b1;
            end else if (cmpb_ack || (flag_wr && wdata[FLAG_CMPB])) begin
                compare_b_flag <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Register reads
    // ****************************************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= RST_BYTE;
        end else if (rd_stb) begin
            if (addr == a_ctrl) begin
                rdata <= ctrl_reg;
            end else if (addr == a_count) begin
                rdata <= count_value_reg;
            end else if (addr == a_cmpa) begin
                rdata <= compare_a_value_reg;
            end else if (addr == a_cmpb) begin
                rdata <= compare_b_value_reg;
            end else if (addr == a_flags) begin
                rdata <= {5'h00, compare_b_flag, compare_a_flag, overflow_flag};
            end else begin
                rdata <= RST_BYTE;
            end
        end else begin
            rdata <= RST_BYTE;
        end
    end

    // ****************************************************************
    // Compare output units
    // ****************************************************************
    assign if_a.match      = cmpa_set;
    assign if_a.restart    = timer_tick && (mode_class == CLS_FAST) && at_top;
    assign if_a.dir_up     = dir_up_reg;
    assign if_a.pwm        = is_pwm;
    assign if_a.fast       = (mode_class == CLS_FAST);
    assign if_a.cmp_is_top = (cmpa_eff == top_value);
    assign if_a.toggle_ok  = waveform_mode_sel[MODE_HIGH_BIT];

    assign if_b.match      = cmpb_set;
    assign if_b.restart    = timer_tick && (mode_class == CLS_FAST) && at_top;
    assign if_b.dir_up     = dir_up_reg;
    assign if_b.pwm        = is_pwm;
    assign if_b.fast       = (mode_class == CLS_FAST);
    assign if_b.cmp_is_top = (cmpb_eff == top_value);
    assign if_b.toggle_ok  = 1'b0;

    t8w_compare u_cmp_a (
        .clk        (clk),
        .rstn       (rstn),
        .ev         (if_a),
        .action_sel (out_a_action_sel),
        .wave       (wave_out_a),
        .connected  (wave_a_connected)
    );

    t8w_compare u_cmp_b (
        .clk        (clk),
        .rstn       (rstn),
        .ev         (if_b),
        .action_sel (out_b_action_sel),
        .wave       (wave_out_b),
        .connected  (wave_b_connected)
    );

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_normal_wrap;
        @(posedge clk) disable iff (!rstn)
        (timer_tick && !cnt_wr && waveform_mode_sel == MODE_NORMAL && count_value_reg == CNT_MAX)
            |=> (count_value_reg == CNT_BOTTOM) && overflow_flag;
    endproperty
    a_normal_wrap: assert property (p_normal_wrap) else $error("normal mode wrap or overflow wrong");

    property p_normal_ovf_only_at_wrap;
        @(posedge clk) disable iff (!rstn)
        ($rose(overflow_flag) && $past(mode_class) == CLS_NORMAL) |-> $past(count_value_reg) == CNT_MAX;
    endproperty
    a_normal_ovf_only_at_wrap: assert property (p_normal_ovf_only_at_wrap) else $error("overflow set off wrap");

    property p_ack_clears;
        @(posedge clk) disable iff (!rstn)
        (ovf_ack && !ovf_set) |=> !overflow_flag;
    endproperty
    a_ack_clears: assert property (p_ack_clears) else $error("overflow not cleared by service");

    property p_count_write;
        @(posedge clk) disable iff (!rstn)
        cnt_wr |=> count_value_reg == $past(wdata);
    endproperty
    a_count_write: assert property (p_count_write) else $error("counter write lost");

    property p_ctc_clear;
        @(posedge clk) disable iff (!rstn)
        (timer_tick && !cnt_wr && mode_class == CLS_CTC && count_value_reg == compare_a_value_reg)
            |=> (count_value_reg == CNT_BOTTOM) && compare_a_flag;
    endproperty
    a_ctc_clear: assert property (p_ctc_clear) else $error("CLEAR_ON_MATCH_MODE did not clear at compare A");

    property p_fast_restart;
        @(posedge clk) disable iff (!rstn)
        (timer_tick && !cnt_wr && mode_class == CLS_FAST && at_top)
            |=> (count_value_reg == CNT_BOTTOM) && overflow_flag;
    endproperty
    a_fast_restart: assert property (p_fast_restart) else $error("fast PWM restart or overflow wrong");

    property p_phase_reverse;
        @(posedge clk) disable iff (!rstn)
        (timer_tick && !cnt_wr && mode_class == CLS_PHASE && dir_up_reg && at_top && !at_top_zero)
            |=> !dir_up_reg && (count_value_reg == $past(count_value_reg) - CNT_ONE);
    endproperty
    a_phase_reverse: assert property (p_phase_reverse) else $error("phase PWM did not reverse at TOP");

    property p_phase_ovf;
        @(posedge clk) disable iff (!rstn)
        (timer_tick && mode_class == CLS_PHASE && !dir_up_reg && count_value_reg == CNT_BOTTOM)
            |=> overflow_flag;
    endproperty
    a_phase_ovf: assert property (p_phase_ovf) else $error("phase PWM overflow missing at bottom");

    property p_hold_without_tick;
        @(posedge clk) disable iff (!rstn)
        (!timer_tick && !cnt_wr) |=> $stable(count_value_reg);
    endproperty
    a_hold_without_tick: assert property (p_hold_without_tick) else $error("counter moved without tick");

endmodule

// file: tb/t8w_pin_model.sv
// Port pin model standing beside one compare output.
`timescale 1ns/1ps
module t8w_pin_model (
    input  wire logic wave,
    input  wire logic connected,
    input  wire logic dir_out,
    input  wire logic port_val,
    output logic      pin
);
    // The pin floats high through a pull-up while the port leaves it as input.
    assign pin = !dir_out ? 1'b1 : (connected ? wave : port_val);
endmodule

// file: tb/tb.sv
// Register level test of the 8-bit waveform timer.
`timescale 1ns/1ps
module tb;
    import t8w_pkg::*;
    logic       clk = 0, rstn = 0, tick = 0, wr = 0, rd = 0, oa = 0, ca = 0, cb = 0;
    logic [4:0] addr = 5'h00;
    logic [7:0] wd = 8'h00, rdata;
    logic       ovf, fa, fb, wa, wb, cna, cnb, dir_out = 0, pin;
    int         failures = 0, compares = 0;
    t8w_timer t8w_timer_inst (.clk(clk), .rstn(rstn), .timer_tick(tick), .addr(addr), .wdata(wd),
        .wr_stb(wr), .rd_stb(rd), .rdata(rdata), .ovf_ack(oa), .cmpa_ack(ca), .cmpb_ack(cb),
        .overflow_flag(ovf), .compare_a_flag(fa), .compare_b_flag(fb), .wave_out_a(wa),
        .wave_out_b(wb), .wave_a_connected(cna), .wave_b_connected(cnb));
    t8w_pin_model t8w_pin_model_inst (.wave(wa), .connected(cna), .dir_out(dir_out), .port_val(1'b0),
        .pin(pin));
    // ****************************************************************
    // Bus and check tasks
    // ****************************************************************
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        compares++;
        if (s !== e) begin
            failures++;
            $display("mismatch %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic wrr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk) begin wr <= 1; addr <= a; wd <= d; end
        @(posedge clk) wr <= 0;
    endtask
    task automatic rdc(input string n, input logic [4:0] a, input logic [7:0] e);
        @(posedge clk) begin rd <= 1; addr <= a; end
        @(posedge clk) rd <= 0;
        #1 chk(n, rdata, e);
    endtask
    // Holds the enable for n consecutive cycles, so n ticks are taken.
    task automatic ticks(input int n);
        repeat (n) @(posedge clk) tick <= 1;
        @(posedge clk) tick <= 0;
        #1;
    endtask
    task automatic pulse_ack();
        @(posedge clk) begin oa <= 1; ca <= 1; cb <= 1; end
        @(posedge clk) begin oa <= 0; ca <= 0; cb <= 0; end
        #1;
    endtask
    task automatic end_of_test();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial forever #2.5 clk = ~clk;
    initial begin
        #100000;
        failures++;
        end_of_test();
    end
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1;
        rdc("ctrl", ADDR_CTRL, RST_BYTE);
        rdc("unmapped", 5'h14, 8'h00);
        wrr(ADDR_COUNT, CNT_MAX);
        ticks(1);
        chk("ovf", {7'h0, ovf}, 8'h01);
        rdc("wrap", ADDR_COUNT, CNT_BOTTOM);
        pulse_ack();
        chk("ovf_ack", {7'h0, ovf}, 8'h00);
        wrr(ADDR_CTRL, {ACT_TOGGLE, 3'h0, MODE_CTC});
        wrr(ADDR_CMPA, 8'h03);
        wrr(ADDR_COUNT, 8'h00);
        ticks(4);
        rdc("ctc_clear", ADDR_COUNT, 8'h00);
        chk("cmpa_flag", {7'h0, fa}, 8'h01);
        chk("toggle", {7'h0, wa}, 8'h01);
        chk("conn", {7'h0, cna}, 8'h01);
        chk("conn_b", {7'h0, cnb}, 8'h00);
        chk("cmpb_flag", {7'h0, fb}, 8'h01);
        chk("pin_in", {7'h0, pin}, 8'h01);
        @(posedge clk) dir_out <= 1;
        #1 chk("pin_out", {7'h0, pin}, 8'h01);
        wrr(ADDR_COUNT, 8'h05);
        ticks(250);
        chk("no_ovf_yet", {7'h0, ovf}, 8'h00);
        ticks(1);
        chk("ctc_ovf", {7'h0, ovf}, 8'h01);
        wrr(ADDR_FLAGS, 8'h07);
        rdc("flags_clr", ADDR_FLAGS, 8'h00);
        wrr(ADDR_CTRL, {ACT_CLEAR, 3'h0, MODE_FAST_MAX});
        wrr(ADDR_COUNT, 8'hFE);
        ticks(1);
        chk("fast_top_noovf", {7'h0, ovf}, 8'h00);
        ticks(1);
        chk("fast_ovf", {7'h0, ovf}, 8'h01);
        rdc("fast_restart", ADDR_COUNT, 8'h00);
        pulse_ack();
        wrr(ADDR_CTRL, {ACT_CLEAR, 3'h0, MODE_PHASE_MAX});
        wrr(ADDR_COUNT, CNT_MAX);
        ticks(1);
        rdc("phase_rev", ADDR_COUNT, 8'hFE);
        wrr(ADDR_COUNT, CNT_ONE);
        ticks(1);
        chk("phase_noovf", {7'h0, ovf}, 8'h00);
        ticks(1);
        chk("phase_ovf", {7'h0, ovf}, 8'h01);
        rdc("phase_up", ADDR_COUNT, CNT_ONE);
        // Mode 7: the first period still runs to the old buffered TOP of 3.
        wrr(ADDR_CMPA, 8'h04);
        wrr(ADDR_CMPB, 8'h02);
        wrr(ADDR_CTRL, {ACT_CLEAR, ACT_SET, 1'b0, MODE_FAST_CMP});
        ticks(3);
        rdc("fast7_old_top", ADDR_COUNT, 8'h00);
        ticks(3);
        chk("fast7_b_set", {7'h0, wb}, 8'h01);
        rdc("fast7_cnt", ADDR_COUNT, 8'h03);
        chk("fast7_b_conn", {7'h0, cnb}, 8'h01);
        ticks(2);
        chk("fast7_b_clr", {7'h0, wb}, 8'h00);
        rdc("fast7_new_top", ADDR_COUNT, 8'h00);
        end_of_test();
    end
endmodule
